// ===== hw/adc_seq_defines.svh
`ifndef ADC_SEQ_DEFINES_SVH
`define ADC_SEQ_DEFINES_SVH

// control word positions (13-bit word, first bit shifted is bit 12)
`define CTL_W 13
`define CTL_LOAD 12
`define CTL_ORDER 11
`define CTL_IDX_HI 10
`define CTL_IDX_LO 7
`define CTL_PM_HI 6
`define CTL_PM_LO 5
`define CTL_MASKSEL 4
`define CTL_IDLE 3
`define CTL_SPAN 2
`define CTL_CODE 1
`define CTL_SE 0

// frame timing in serial clock falling edges
`define EDGE_CTL 5'd13
`define EDGE_MUX 5'd14
`define EDGE_END 5'd16

// reset values and the channel picked for an empty mask
`define RST_PM 2'h0
`define RST_CHAN 4'h0
`define RST_MASK 16'h0000
`define ALL_CHAN 4'hf

// wake-up time in ns and its cycle count at 100 MHz, rounded up
`define WAKE_NS 1000
`define CLK_NS 10
`define WAKE_CYC ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== hw/adc_seq_pkg.sv
package adc_seq_pkg;
    typedef enum logic [1:0] {
        SEQ_DIRECT = 2'b00,
        SEQ_MASK = 2'b01,
        SEQ_COUNT = 2'b10
    } seq_mode_t;

    typedef struct packed {
        logic [1:0] power_mode_bits;
        logic idle_output_drive;
        logic input_span_sel;
        logic output_code_sel;
        logic single_ended_sel;
    } ctl_fields_t;

    typedef struct packed {
        logic [3:0] pos_input;
        logic [3:0] neg_input;
        logic differential;
    } mux_sel_t;
endpackage : adc_seq_pkg

// ===== hw/sync2.sv
`timescale 1ns/1ps
module sync2 #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage is read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            q <= '0;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule : sync2

// ===== hw/adc_channel_sequencer.sv
`timescale 1ns/1ps
`include "adc_seq_defines.svh"
module adc_channel_sequencer #(
    parameter int CHANNELS = 16,
    parameter int RES_W = 12,
    parameter int WAKE_CYCLES = `WAKE_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic serial_clock,
    input wire logic chip_select_n,
    input wire logic serial_data_in,
    input wire logic [RES_W-1:0] conv_result,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic serial_data_out_weak,
    output adc_seq_pkg::mux_sel_t mux_sel,
    output logic track_hold,
    output logic input_span,
    output logic powered,
    output logic wake_ready
);
    // ---------------------------------------------------------------
    // link side: serial clock falling edges
    // ---------------------------------------------------------------
    logic link_rst_b;
    logic [4:0] edge_cnt_r;
    logic [15:0] shift_r;
    logic [15:0] dout_shift_r;
    logic [`CTL_W-1:0] ctl_word_r;
    logic [15:0] mask_word_r;
    logic mux_tgl_r;
    logic end_tgl_r;
    logic frame_done_r;

    // frame bookkeeping clears while chip select is high
    assign link_rst_b = rst_b & ~chip_select_n;

    always_ff @(negedge serial_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            edge_cnt_r <= 5'd0;
        end else if (edge_cnt_r != 5'd31) begin
            edge_cnt_r <= edge_cnt_r + 5'd1;
        end
    end

    always_ff @(negedge serial_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            shift_r <= 16'h0000;
        end else begin
            shift_r <= {shift_r[14:0], serial_data_in};
        end
    end

    // words stay put until the next frame, so the core can read them
    // once the event toggle has crossed
    always_ff @(negedge serial_clock or negedge rst_b) begin
        if (!rst_b) begin
            ctl_word_r <= '0;
            mask_word_r <= `RST_MASK;
            mux_tgl_r <= 1'b0;
            end_tgl_r <= 1'b0;
        end else if (!chip_select_n) begin
            if (edge_cnt_r == `EDGE_CTL - 5'd1) begin
                ctl_word_r <= {shift_r[`CTL_W-2:0], serial_data_in};
            end
            if (edge_cnt_r == `EDGE_MUX - 5'd1) begin
                mux_tgl_r <= ~mux_tgl_r;
            end
            if (edge_cnt_r == `EDGE_END - 5'd1) begin
                mask_word_r <= {shift_r[14:0], serial_data_in};
                end_tgl_r <= ~end_tgl_r;
            end
        end
    end

    // result word is static while a frame runs; the first bit sits
    // on the pin from the chip select fall, later bits follow each edge
    logic [15:0] out_word_r;

    always_ff @(negedge serial_clock or negedge link_rst_b) begin
        if (!link_rst_b) begin
            dout_shift_r <= 16'h0000;
            frame_done_r <= 1'b0;
        end else begin
            if (edge_cnt_r == 5'd0) begin
                dout_shift_r <= {out_word_r[14:0], 1'b0};
            end else begin
                dout_shift_r <= {dout_shift_r[14:0], 1'b0};
            end
            if (edge_cnt_r == `EDGE_END - 5'd1) begin
                frame_done_r <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // core side: crossings
    // ---------------------------------------------------------------
    logic [2:0] sync_q;
    logic cs_n_s, mux_tgl_s, end_tgl_s;
    logic cs_n_d_r, mux_tgl_d_r, end_tgl_d_r;
    logic cs_rise, cs_fall, mux_evt, end_evt;

    // select crosses inverted so the synchroniser's reset value is the
    // idle level; otherwise a false frame start follows every reset
    sync2 #(.W(3)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .d({~chip_select_n, mux_tgl_r, end_tgl_r}),
        .q(sync_q)
    );

    assign cs_n_s = ~sync_q[2];
    assign mux_tgl_s = sync_q[1];
    assign end_tgl_s = sync_q[0];

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_n_d_r <= 1'b1;
            mux_tgl_d_r <= 1'b0;
            end_tgl_d_r <= 1'b0;
        end else begin
            cs_n_d_r <= cs_n_s;
            mux_tgl_d_r <= mux_tgl_s;
            end_tgl_d_r <= end_tgl_s;
        end
    end

    assign cs_rise = cs_n_s & ~cs_n_d_r;
    assign cs_fall = ~cs_n_s & cs_n_d_r;
    assign mux_evt = mux_tgl_s ^ mux_tgl_d_r;
    assign end_evt = end_tgl_s ^ end_tgl_d_r;

    // ---------------------------------------------------------------
    // control register and sequencer
    // ---------------------------------------------------------------
    adc_seq_pkg::ctl_fields_t ctl_r;
    adc_seq_pkg::seq_mode_t mode_r;
    logic mask_pending_r;
    logic mask_frame_r;
    logic mask_full_r;
    logic mask_apply_r;
    logic [15:0] mask_r;
    logic [15:0] new_mask_r;
    logic [3:0] index_r;
    logic [3:0] limit_r;
    logic [3:0] cur_chan_r;
    logic [3:0] conv_chan_r;
    logic [CHANNELS-1:0] chan_en;
    logic [CHANNELS-1:0] new_en;

    // mask bit 15 is input 0
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_map
            assign chan_en[gi] = mask_r[CHANNELS-1-gi];
            assign new_en[gi] = new_mask_r[CHANNELS-1-gi];
        end
    endgenerate

    // lowest enabled input strictly above start, else lowest overall
    function automatic logic [3:0] next_en(input logic [CHANNELS-1:0] en,
                                           input logic [3:0] start,
                                           input logic from_bottom);
        logic [3:0] res;
        logic found;
        res = `ALL_CHAN;
        found = 1'b0;
        for (int i = CHANNELS - 1; i >= 0; i--) begin
            if (en[i] && (from_bottom || i > int'(start))) begin
                res = 4'(i);
                found = 1'b1;
            end
        end
        if (!found && !from_bottom) begin
            for (int i = CHANNELS - 1; i >= 0; i--) begin
                if (en[i]) begin
                    res = 4'(i);
                end
            end
        end
        return res;
    endfunction : next_en

    logic ld;
    logic order_bit, mask_bit;
    assign ld = ctl_word_r[`CTL_LOAD] & ~mask_frame_r;
    assign order_bit = ctl_word_r[`CTL_ORDER];
    assign mask_bit = ctl_word_r[`CTL_MASKSEL];

    // a frame that follows a mask-select write carries the mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_frame_r <= 1'b0;
        end else if (cs_fall) begin
            mask_frame_r <= mask_pending_r;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl_r <= '{power_mode_bits: `RST_PM, default: 1'b0};
            mode_r <= adc_seq_pkg::SEQ_DIRECT;
            mask_pending_r <= 1'b0;
            index_r <= `RST_CHAN;
            limit_r <= `RST_CHAN;
        end else if (mux_evt && ld) begin
            ctl_r.power_mode_bits <= ctl_word_r[`CTL_PM_HI:`CTL_PM_LO];
            ctl_r.idle_output_drive <= ctl_word_r[`CTL_IDLE];
            ctl_r.input_span_sel <= ctl_word_r[`CTL_SPAN];
            ctl_r.output_code_sel <= ctl_word_r[`CTL_CODE];
            ctl_r.single_ended_sel <= ctl_word_r[`CTL_SE];
            mask_pending_r <= ~order_bit & mask_bit;
            if (!(order_bit && !mask_bit)) begin
                index_r <= ctl_word_r[`CTL_IDX_HI:`CTL_IDX_LO];
                if (order_bit) begin
                    mode_r <= adc_seq_pkg::SEQ_COUNT;
                    limit_r <= ctl_word_r[`CTL_IDX_HI:`CTL_IDX_LO];
                end else begin
                    mode_r <= adc_seq_pkg::SEQ_DIRECT;
                end
            end
        end else if (mask_apply_r) begin
            mode_r <= adc_seq_pkg::SEQ_MASK;
            mask_pending_r <= 1'b0;
        end
    end

    // end toggle and select rise cross in the same flops and may land in
    // one cycle, so the mask is applied one cycle after the rise
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mask_apply_r <= 1'b0;
        end else begin
            mask_apply_r <= cs_rise & (mask_full_r | (end_evt & mask_frame_r));
        end
    end

    // the mask only counts when all 16 edges arrived
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            new_mask_r <= `RST_MASK;
            mask_full_r <= 1'b0;
            mask_r <= `RST_MASK;
        end else begin
            if (end_evt && mask_frame_r) begin
                new_mask_r <= mask_word_r;
                mask_full_r <= 1'b1;
            end else if (mask_apply_r) begin
                mask_full_r <= 1'b0;
            end
            if (mask_apply_r) begin
                mask_r <= new_mask_r;
            end
        end
    end

    // channel for the next conversion, picked at the 14th edge, or after the rise when the frame carried a mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cur_chan_r <= `RST_CHAN;
        end else if (mask_apply_r) begin
            cur_chan_r <= next_en(new_en, 4'h0, 1'b1);
        end else if (mux_evt && !mask_frame_r) begin
            if (ld && !(order_bit && !mask_bit)) begin
                cur_chan_r <= order_bit ? 4'h0 : ctl_word_r[`CTL_IDX_HI:`CTL_IDX_LO];
            end else begin
                unique case (mode_r)
                    adc_seq_pkg::SEQ_DIRECT: cur_chan_r <= index_r;
                    adc_seq_pkg::SEQ_MASK: cur_chan_r <= next_en(chan_en, cur_chan_r, 1'b0);
                    adc_seq_pkg::SEQ_COUNT: cur_chan_r <= (cur_chan_r >= limit_r) ? 4'h0
                                                       : cur_chan_r + 4'h1;
                    default: cur_chan_r <= index_r;
                endcase
            end
        end
    end

    // channel converted in the running frame is latched at its start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            conv_chan_r <= `RST_CHAN;
        end else if (cs_fall) begin
            conv_chan_r <= cur_chan_r;
        end
    end

    // ---------------------------------------------------------------
    // result word, multiplexer and power
    // ---------------------------------------------------------------
    // only rewritten while chip select is high, so the link reads it
    // stable; a frame started within two cycles of the rise sees old data
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            out_word_r <= 16'h0000;
        end else if (cs_n_s && cs_n_d_r) begin
            out_word_r <= {cur_chan_r,
                           conv_result[RES_W-1] ^ ~ctl_r.output_code_sel,
                           conv_result[RES_W-2:0]};
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mux_sel <= '0;
        end else begin
            mux_sel.pos_input <= cur_chan_r;
            mux_sel.neg_input <= cur_chan_r ^ 4'h1;
            mux_sel.differential <= ~ctl_r.single_ended_sel;
        end
    end

    // hold from chip select fall; track again at the 14th edge, or at
    // the rise when the frame carried a mask
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            track_hold <= 1'b1;
        end else if (cs_fall) begin
            track_hold <= 1'b0;
        end else if ((mux_evt && !mask_frame_r) || cs_rise) begin
            track_hold <= powered;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            input_span <= 1'b0;
        end else begin
            input_span <= ctl_r.input_span_sel;
        end
    end

    logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_r;

    // power-on leaves the converter asleep until the first frame
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            powered <= 1'b0;
        end else if (cs_fall) begin
            powered <= 1'b1;
        end else if (mux_evt && ld && !ctl_word_r[`CTL_PM_HI]) begin
            powered <= 1'b0;
        end else if (ctl_r.power_mode_bits == 2'h3) begin
            powered <= 1'b1;
        end
    end

    // tells the host side when a result is trustworthy again
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wake_cnt_r <= '0;
            wake_ready <= 1'b0;
        end else if (!powered) begin
            wake_cnt_r <= '0;
            wake_ready <= 1'b0;
        end else if (wake_cnt_r != ($clog2(WAKE_CYCLES+1))'(WAKE_CYCLES)) begin
            wake_cnt_r <= wake_cnt_r + 1'b1;
        end else begin
            wake_ready <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // serial output pin
    // ---------------------------------------------------------------
    // pin-level mux: the first address bit must appear before any edge
    always_comb begin
        serial_data_out = (edge_cnt_r == 5'd0) ? out_word_r[15] : dout_shift_r[15];
        serial_data_out_oe = ~chip_select_n & ~frame_done_r;
        serial_data_out_weak = ctl_r.idle_output_drive & ~serial_data_out_oe;
    end
endmodule : adc_channel_sequencer

// ===== test/adc_channel_sequencer_sva.sv
`timescale 1ns/1ps
module adc_channel_sequencer_sva #(
    parameter int WAKE_CYCLES = 100
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic chip_select_n,
    input wire logic serial_data_out_oe,
    input wire logic serial_data_out_weak,
    input wire adc_seq_pkg::mux_sel_t mux_sel,
    input wire logic track_hold,
    input wire logic input_span,
    input wire logic powered,
    input wire logic wake_ready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    // ----------------------------------------
    // cycles since the converter last powered up
    // ----------------------------------------
    logic [7:0] up_cnt_r;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            up_cnt_r <= 8'h00;
        end else if (!powered) begin
            up_cnt_r <= 8'h00;
        end else if (up_cnt_r != 8'hff) begin
            up_cnt_r <= up_cnt_r + 8'h01;
        end
    end

    sequence frame_start;
        $fell(chip_select_n);
    endsequence
    // settling of both crossings is well inside eight quiet cycles
    sequence cs_quiet;
        chip_select_n [*8];
    endsequence

    out_drive_a: assert property (frame_start |-> ##[0:1] serial_data_out_oe)
        else $error("data out not driven after frame start");
    oe_idle_a: assert property (chip_select_n [*2] |-> !serial_data_out_oe)
        else $error("data out driven outside a frame");
    weak_excl_a: assert property (serial_data_out_oe |-> !serial_data_out_weak)
        else $error("strong and weak drive together");
    hold_on_frame_a: assert property (frame_start |-> ##[1:6] !track_hold)
        else $error("no hold after frame start");
    wake_on_frame_a: assert property (frame_start |-> ##[1:6] powered)
        else $error("converter not woken by frame start");
    wake_delay_a: assert property (wake_ready && powered |-> up_cnt_r >= WAKE_CYCLES)
        else $error("ready flagged before wake time");
    wake_bound_a: assert property (up_cnt_r == 8'(WAKE_CYCLES + 3) |-> wake_ready)
        else $error("ready flag late");
    sleep_ready_a: assert property (!powered [*2] |-> !wake_ready)
        else $error("ready while shut down");
    mux_steady_a: assert property (cs_quiet |=> $stable(mux_sel))
        else $error("mux moved between frames");
    span_steady_a: assert property (cs_quiet |=> $stable(input_span))
        else $error("span moved between frames");
endmodule : adc_channel_sequencer_sva

bind adc_channel_sequencer adc_channel_sequencer_sva #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
    .clk(clk),
    .rst_b(rst_b),
    .chip_select_n(chip_select_n),
    .serial_data_out_oe(serial_data_out_oe),
    .serial_data_out_weak(serial_data_out_weak),
    .mux_sel(mux_sel),
    .track_hold(track_hold),
    .input_span(input_span),
    .powered(powered),
    .wake_ready(wake_ready)
);

// ===== test/serial_host_model.sv
`timescale 1ns/1ps
module serial_host_model (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    initial begin
        serial_clock = 1'b1;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // ----------------------------------------
    // one 16-edge frame, first bit first
    // ----------------------------------------
    // clock only runs inside the frame; data line flips after it so a
    // stale value is never mistaken for a driven one
    task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
        chip_select_n = 1'b0;
        serial_data_in = w[15];
        #5;
        for (int i = 15; i >= 0; i--) begin
            rd[i] = serial_data_out;
            serial_clock = 1'b0;
            #3;
            serial_clock = 1'b1;
            if (i > 0) serial_data_in = w[i-1];
            #3;
        end
        chip_select_n = 1'b1;
        serial_data_in = ~w[0];
    endtask : xfer
endmodule : serial_host_model

// ===== test/adc_channel_sequencer_test.sv
`timescale 1ns/1ps
module adc_channel_sequencer_test;
    logic clk, rst_b, serial_clock, chip_select_n, serial_data_in;
    logic serial_data_out, serial_data_out_oe, serial_data_out_weak;
    logic track_hold, input_span, powered, wake_ready;
    logic [11:0] conv_result, res;
    adc_seq_pkg::mux_sel_t mux_sel;
    int failures, n_tests, seed, i, j, r;
    logic [3:0] cur;
    logic cur_ok, mask_pend, code_q, span_q;
    logic [1:0] pm_q;
    logic [2:0] lo;
    logic [15:0] m;

    adc_channel_sequencer #(.WAKE_CYCLES(3)) dut (
        .clk(clk), .rst_b(rst_b), .serial_clock(serial_clock),
        .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
        .conv_result(conv_result), .serial_data_out(serial_data_out),
        .serial_data_out_oe(serial_data_out_oe), .serial_data_out_weak(serial_data_out_weak),
        .mux_sel(mux_sel), .track_hold(track_hold), .input_span(input_span),
        .powered(powered), .wake_ready(wake_ready));

    serial_host_model host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out));

    always #5 clk = ~clk;

    // ----------------------------------------
    // compares and expectations
    // ----------------------------------------
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : check

    task automatic check_mux(input logic [3:0] ch, input logic se);
        n_tests++;
        if (mux_sel.pos_input !== ch || mux_sel.differential !== !se
                || (!se && mux_sel.neg_input !== (ch ^ 4'h1))) begin
            failures++;
            $display("BAD %0t mux %h exp channel %h", $time, mux_sel, ch);
        end
    endtask : check_mux

    function automatic logic [15:0] ctl(logic ld, logic od, logic [3:0] ix, logic [1:0] pm,
            logic ms, logic [3:0] low);
        return {ld, od, ix, pm, ms, low, 3'b000};
    endfunction : ctl

    // next set input after ch, ascending with wrap; empty mask falls back to 15
    function automatic logic [3:0] nxt_in(logic [15:0] mk, logic [3:0] ch);
        logic [3:0] k;
        nxt_in = 4'hf;
        for (int s = 16; s >= 1; s--) begin
            k = ch + 4'(s);
            if (mk[15 - k]) nxt_in = k;
        end
    endfunction : nxt_in

    // results are only trusted when the previous write kept the part powered
    task automatic frame(input logic [15:0] w, input logic [3:0] nx, input logic se,
            input logic chk);
        logic [15:0] rd;
        logic ld;
        host.xfer(w, rd);
        ld = w[15] && !mask_pend;
        if (cur_ok) check(16'(rd[15:12]), 16'(cur));
        if (pm_q == 2'b11) check(16'(rd[11:0]), 16'(code_q ? res : res ^ 12'h800));
        if (ld) begin
            pm_q = w[9:8];
            code_q = w[4];
            span_q = w[5];
        end
        mask_pend = ld && !w[14] && w[7];
        @(negedge clk);
        conv_result = 12'($random(seed));
        res = conv_result;
        repeat (10) @(negedge clk);
        check(16'(powered), 16'(!(ld && !w[9])));
        check(16'(input_span), 16'(span_q));
        if (chk) check_mux(nx, se);
        cur = nx;
        cur_ok = chk;
    endtask : frame

    task conclude;
        if (failures == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : conclude

    initial begin
        #200000;
        failures++;
        conclude();
    end

    initial begin
        clk = 1'b0;
        rst_b = 1'b0;
        seed = 87;
        conv_result = 12'h5a3;
        res = conv_result;
        {failures, n_tests} = 0;
        {cur, cur_ok, mask_pend, code_q, span_q, pm_q} = {4'h0, 1'b1, 5'h00};
        repeat (19) @(negedge clk);
        check(16'({mux_sel, track_hold, input_span, powered, wake_ready,
            serial_data_out_oe, serial_data_out_weak}), 16'h0020);
        @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        check(16'({powered, track_hold}), 16'h0001);
        for (i = 0; i < 32; i++) begin
            lo = 3'($random(seed));
            frame(ctl(1, 0, i[3:0], 2'b11, 0, {lo, i[4]}), i[3:0], i[4], 1);
        end
        frame(ctl(0, 0, 4'h3, 2'b00, 0, 4'h0), 4'hf, 1, 1);
        frame(ctl(1, 1, 4'h3, 2'b11, 1, 4'b0001), 4'h0, 1, 1);
        for (i = 1; i < 6; i++) frame({1'b0, 15'($random(seed))}, 4'(i % 4), 1, 1);
        frame(ctl(1, 1, 4'h9, 2'b11, 0, 4'b0101), 4'h2, 1, 1);
        frame({1'b0, 15'($random(seed))}, 4'h3, 1, 1);
        frame({1'b0, 15'($random(seed))}, 4'h0, 1, 1);
        for (r = 0; r < 2; r++) begin
            m = (r != 0) ? 16'h0000 : (16'($random(seed)) | 16'h0400);
            frame(ctl(1, 0, 4'h0, 2'b11, 1, 4'b0001), cur, 1, 0);
            frame(m, nxt_in(m, 4'hf), 1, 1);
            for (j = 0; j < 4; j++) frame({1'b0, 15'($random(seed))}, nxt_in(m, cur), 1, 1);
        end
        frame(ctl(1, 0, 4'h4, 2'b00, 0, 4'b0011), 4'h4, 1, 1);
        frame({1'b0, 15'($random(seed))}, 4'h4, 1, 1);
        check(16'(wake_ready), 16'h0001);
        conclude();
    end
endmodule : adc_channel_sequencer_test
